/* hdl/css_regs.svh */
// constants for the clock source and start-up sequencer
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CSS_ADDR_TRIM 8'h00
`define CSS_ADDR_STATUS 8'h01
`define CSS_ADDR_CONFIG 8'h02
`define CSS_ADDR_SLEEP 8'h03
// ---------------------------------------------------------------
// fuse codes
// ---------------------------------------------------------------
`define CSS_SRC_EXT 4'h0
`define CSS_SRC_RC 4'h2
`define CSS_SRC_WDT 4'h4
`define CSS_SRC_LFX 4'h6
`define CSS_SUT_SHORT 2'h0
`define CSS_SUT_MID 2'h1
`define CSS_SUT_LONG 2'h2
`define CSS_SUT_RSVD 2'h3
// ---------------------------------------------------------------
// start-up counts
// ---------------------------------------------------------------
`define CSS_PD_FAST 16'h0006
`define CSS_RST_EXTRA 16'h000E
`define CSS_LFX_1K 16'h0400
`define CSS_TIME_4MS 4
`define CSS_TIME_64MS 64
`define CSS_WDT_4MS 14'h0200
`define CSS_WDT_64MS_DEF 8192
`define CSS_LFX_32K_DEF 32768
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CSS_SLEEP_BIT 0
`define CSS_TRIM_RST 8'h00
`endif

/* hdl/css_pkg.sv */
// types for the clock source and start-up sequencer
package css_pkg;
	typedef enum logic [4:0] {
		CSS_SAMPLE = 5'h01,
		CSS_RST_WAIT = 5'h02,
		CSS_RUN = 5'h04,
		CSS_SLEEP = 5'h08,
		CSS_WAKE = 5'h10
	} css_state_t;

	typedef struct packed {
		logic [3:0] clock_source_select_code;
		logic [1:0] startup_time_code;
		logic divide_by_eight_fuse;
	} css_fuse_t;

	typedef struct packed {
		logic rc_osc;
		logic external_clock_input;
		logic lf_crystal;
		logic wdt_osc;
		logic hf_crystal;
	} css_osc_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} css_bus_t;

	typedef struct packed {
		css_state_t state;
		css_fuse_t fuse;
		logic [7:0] oscillator_trim_register;
		logic src_prev;
		logic wdt_prev;
		logic [15:0] src_cnt;
		logic [13:0] wdt_cnt;
		logic [7:0] rdata;
		logic sys_clk;
		logic wdt_clk;
		logic core_reset_n;
		logic cpu_run;
		logic div8;
	} css_st_t;
endpackage

/* hdl/css_clock_source_startup_select.sv */
// clock source selection and start-up delay sequencer
// Functional notes
// - code 0110 runs the system from the low-frequency watch crystal
// - watch crystal timing: 00 1K+4ms, 01 1K+64ms, 10 32K+64ms, 11 reserved; code counts LFX_32K_CYCLES minus one (32767) for 32K; counts run in parallel
// - internal rc oscillator nominal 8MHz, no external parts needed
// - every reset copies factory calibration into the trim register
// - software may rewrite the trim register; oscillator follows it
// - watchdog clock and reset time-out keep using the watchdog oscillator
// - rc oscillator: 6 cycles from sleep; reset adds 14, 14+4ms, 14+64ms; code counts the two in parallel, releasing on the longer
// - shipped setting is rc oscillator, code 10, divide-by-eight programmed
// - code 0000 takes system clock straight from external clock input
// - external clock: 6 cycles from sleep; reset adds 14, 14+4ms, 14+64ms; code counts the two in parallel, releasing on the longer
// - code 0100 runs system clock from the 128kHz oscillator
// - 128kHz oscillator: 6 cycles from sleep; reset adds 14, 14+4ms, 14+64ms; code counts the two in parallel, releasing on the longer
// - real-time delay counted as 512 or 8192 watchdog oscillator cycles
// - wake-up count runs on the selected source before code executes
// - codes 0101,0111,0011,0001 reserved; 1000-1111 select crystal oscillator
`timescale 1ns/1ps
`include "css_regs.svh"

module css_clock_source_startup_select #(
	parameter int WDT_64MS_CYCLES = `CSS_WDT_64MS_DEF,
	parameter int LFX_32K_CYCLES = `CSS_LFX_32K_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire css_pkg::css_fuse_t fuse_in,
	input wire logic [7:0] factory_cal,
	input wire css_pkg::css_osc_t osc_in,
	input wire logic wake,
	input wire css_pkg::css_bus_t bus,
	output logic [7:0] rdata,
	output logic [7:0] oscillator_trim_register,
	output logic sys_clk,
	output logic wdt_clk,
	output logic core_reset_n,
	output logic cpu_run,
	output logic divide_by_eight
);
	import css_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	css_st_t st;
	css_st_t next_st;
	logic src_level;
	logic src_edge;
	logic wdt_edge;
	logic [1:0] sut_eff;
	logic [15:0] src_target;
	logic [13:0] wdt_target;
	logic src_done;
	logic wdt_done;
	logic trim_wr;
	logic sleep_wr;
	logic [7:0] read_word;
	logic [15:0] src_cnt_up;
	logic [13:0] wdt_cnt_up;

	// ---------------------------------------------------------------
	// source selection
	// ---------------------------------------------------------------
	always_comb begin
		src_level = osc_in.rc_osc;
		if (st.fuse.clock_source_select_code[3]) begin
			src_level = osc_in.hf_crystal;
		end else if (st.fuse.clock_source_select_code == `CSS_SRC_EXT) begin
			src_level = osc_in.external_clock_input;
		end else if (st.fuse.clock_source_select_code == `CSS_SRC_WDT) begin
			src_level = osc_in.wdt_osc;
		end else if (st.fuse.clock_source_select_code == `CSS_SRC_LFX) begin
			src_level = osc_in.lf_crystal;
		end else if (st.fuse.clock_source_select_code == `CSS_SRC_RC) begin
			src_level = osc_in.rc_osc;
		end else begin
			// reserved codes fall back to the rc oscillator
			src_level = osc_in.rc_osc;
		end
	end

	// inputs are synchronous, so a registered copy is enough for edges
	assign src_edge = src_level & ~st.src_prev;
	assign wdt_edge = osc_in.wdt_osc & ~st.wdt_prev;

	// ---------------------------------------------------------------
	// start-up targets
	// ---------------------------------------------------------------
	always_comb begin
		sut_eff = st.fuse.startup_time_code;
		if (st.fuse.startup_time_code == `CSS_SUT_RSVD) begin
			sut_eff = `CSS_SUT_LONG;
		end
	end

	always_comb begin
		src_target = `CSS_PD_FAST;
		if (st.fuse.clock_source_select_code == `CSS_SRC_LFX) begin
			// watch crystal counts 1K or 32K
			if (sut_eff == `CSS_SUT_LONG) begin
				src_target = 16'(LFX_32K_CYCLES - 1);
			end else begin
				src_target = `CSS_LFX_1K;
			end
		end else if (st.state == CSS_RST_WAIT) begin
			src_target = `CSS_RST_EXTRA;
		end else begin
			src_target = `CSS_PD_FAST;
		end
	end

	always_comb begin
		wdt_target = 14'h0000;
		if (st.fuse.clock_source_select_code == `CSS_SRC_LFX) begin
			// watch crystal always adds real time
			if (sut_eff == `CSS_SUT_SHORT) begin
				wdt_target = `CSS_WDT_4MS;
			end else begin
				wdt_target = 14'(WDT_64MS_CYCLES);
			end
		end else if (sut_eff == `CSS_SUT_MID) begin
			wdt_target = `CSS_WDT_4MS;
		end else if (sut_eff == `CSS_SUT_LONG) begin
			wdt_target = 14'(WDT_64MS_CYCLES);
		end else begin
			wdt_target = 14'h0000;
		end
	end

	// 32K fits 16 bits, yet the long crystal target is LFX_32K_CYCLES minus one, 32767 by default
	assign src_done = (st.src_cnt >= src_target);
	assign wdt_done = (st.wdt_cnt >= wdt_target);

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	always_comb begin
		// counts stop at their target so a long stay in run never wraps
		src_cnt_up = st.src_cnt;
		wdt_cnt_up = st.wdt_cnt;
		// wake count runs on the selected source
		if (src_edge && !src_done) begin
			src_cnt_up = 16'(st.src_cnt + 16'h0001);
		end
		// reset time-out timed by watchdog oscillator
		if (wdt_edge && !wdt_done) begin
			wdt_cnt_up = 14'(st.wdt_cnt + 14'h0001);
		end
	end

	// ---------------------------------------------------------------
	// register bus decode
	// ---------------------------------------------------------------
	always_comb begin
		trim_wr = 1'b0;
		sleep_wr = 1'b0;
		// a write in the sample cycle is ignored, else it would override the factory load
		if (bus.wr && st.state != CSS_SAMPLE) begin
			if (bus.addr == `CSS_ADDR_TRIM) begin
				trim_wr = 1'b1;
			end else if (bus.addr == `CSS_ADDR_SLEEP) begin
				sleep_wr = bus.wdata[`CSS_SLEEP_BIT];
			end
		end
	end

	always_comb begin
		read_word = 8'h00;
		if (bus.addr == `CSS_ADDR_TRIM) begin
			read_word = st.oscillator_trim_register;
		end else if (bus.addr == `CSS_ADDR_STATUS) begin
			read_word = {1'b0, st.cpu_run, st.core_reset_n, st.state};
		end else if (bus.addr == `CSS_ADDR_CONFIG) begin
			// config reads back the held fuse copy
			read_word = {1'b0, st.fuse};
		end else begin
			// sleep control is write-only, unmapped reads give zero
			read_word = 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.src_prev = src_level;
		next_st.wdt_prev = osc_in.wdt_osc;
		// watchdog clock always from its own oscillator
		next_st.wdt_clk = osc_in.wdt_osc;
		next_st.rdata = 8'h00;
		next_st.src_cnt = src_cnt_up;
		next_st.wdt_cnt = wdt_cnt_up;
		// ---------------------------------------------------------------
		// sequencer
		// ---------------------------------------------------------------
		case (st.state)
			CSS_SAMPLE: begin
				next_st.fuse = fuse_in;
				next_st.oscillator_trim_register = factory_cal;
				next_st.div8 = ~fuse_in.divide_by_eight_fuse;
				next_st.src_cnt = 16'h0000;
				next_st.wdt_cnt = 14'h0000;
				next_st.state = CSS_RST_WAIT;
			end
			CSS_RST_WAIT: begin
				if (src_done && wdt_done) begin
					next_st.core_reset_n = 1'b1;
					next_st.cpu_run = 1'b1;
					next_st.state = CSS_RUN;
				end
			end
			CSS_RUN: begin
				if (sleep_wr) begin
					next_st.cpu_run = 1'b0;
					next_st.state = CSS_SLEEP;
				end
			end
			CSS_SLEEP: begin
				next_st.src_cnt = 16'h0000;
				next_st.wdt_cnt = 14'h0000;
				if (wake) begin
					next_st.state = CSS_WAKE;
				end
			end
			CSS_WAKE: begin
				// code runs only after stable count
				if (src_done) begin
					next_st.cpu_run = 1'b1;
					next_st.state = CSS_RUN;
				end
			end
			default: begin
				next_st.state = CSS_SAMPLE;
			end
		endcase
		// clock is only passed on while the core may run
		next_st.sys_clk = next_st.cpu_run & src_level;
		if (trim_wr) begin
			next_st.oscillator_trim_register = bus.wdata;
		end
		// read data stands for one cycle only, zero otherwise
		if (bus.rd) begin
			next_st.rdata = read_word;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st.state <= CSS_SAMPLE;
			// shipped rc, long start-up, divide by eight
			st.fuse <= {`CSS_SRC_RC, `CSS_SUT_LONG, 1'b0};
			st.oscillator_trim_register <= `CSS_TRIM_RST;
			st.src_prev <= 1'b0;
			st.wdt_prev <= 1'b0;
			st.src_cnt <= 16'h0000;
			st.wdt_cnt <= 14'h0000;
			st.rdata <= 8'h00;
			st.sys_clk <= 1'b0;
			st.wdt_clk <= 1'b0;
			st.core_reset_n <= 1'b0;
			st.cpu_run <= 1'b0;
			st.div8 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign rdata = st.rdata;
	assign oscillator_trim_register = st.oscillator_trim_register;
	assign sys_clk = st.sys_clk;
	assign wdt_clk = st.wdt_clk;
	assign core_reset_n = st.core_reset_n;
	assign cpu_run = st.cpu_run;
	assign divide_by_eight = st.div8;
endmodule

/* sim/css_osc_model.sv */
// oscillator and external clock source model for the start-up sequencer
`timescale 1ns/1ps

module css_osc_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	output css_pkg::css_osc_t osc
);
	import css_pkg::*;
	logic [4:0] c;
	logic ph;
	// rate steady, changed only in reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			c <= 5'h00;
			ph <= 1'b0;
		end else begin
			ph <= ~ph;
			if (!slow || ph) begin
				c <= c + 5'h01;
			end
		end
	end
	// distinct rates so a wrong source choice shows in the timing, except rc and watch crystal, which share c[0]
	assign osc = '{c[0], c[2], c[0], c[1], c[3]};
endmodule

/* sim/css_chk.sv */
// port assertions for the clock source and start-up sequencer
`timescale 1ns/1ps

module css_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire css_pkg::css_fuse_t fuse_in,
	input wire logic [7:0] factory_cal,
	input wire css_pkg::css_osc_t osc_in,
	input wire logic wake,
	input wire css_pkg::css_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic [7:0] oscillator_trim_register,
	input wire logic sys_clk,
	input wire logic wdt_clk,
	input wire logic core_reset_n,
	input wire logic cpu_run,
	input wire logic divide_by_eight
);
	import css_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_boot;
		$rose(nrst);
	endsequence
	sequence s_held;
		!core_reset_n [*8];
	endsequence
	boot_hold_a: assert property (s_boot |-> s_held)
		else $error("core released too early");
	core_stays_a: assert property (core_reset_n |=> core_reset_n)
		else $error("core reset came back");
	run_with_core_a: assert property ($rose(core_reset_n) |-> cpu_run)
		else $error("cpu run not with core release");
	trim_load_a: assert property (
		nrst && !$past(nrst) |=> oscillator_trim_register == $past(factory_cal))
		else $error("trim not loaded");
	trim_write_a: assert property (
		bus.wr && bus.addr == 8'h00 && $past(nrst) |=> oscillator_trim_register == $past(bus.wdata))
		else $error("trim write lost");
	trim_read_a: assert property (
		bus.rd && bus.addr == 8'h00 |=> rdata == $past(oscillator_trim_register))
		else $error("trim read wrong");
	rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not idle");
	wdt_follow_a: assert property ($past(nrst) |-> wdt_clk == $past(osc_in.wdt_osc))
		else $error("watchdog clock lost");
	sys_gate_a: assert property (!cpu_run && !$past(cpu_run) |-> !sys_clk)
		else $error("system clock while halted");
	div8_fuse_a: assert property (
		$past(nrst) && $past(nrst, 2) |-> divide_by_eight == !fuse_in.divide_by_eight_fuse)
		else $error("prescaler start wrong");
endmodule

bind css_clock_source_startup_select css_chk i_chk (.clk(clk), .nrst(nrst), .fuse_in(fuse_in),
	.factory_cal(factory_cal), .osc_in(osc_in), .wake(wake), .bus(bus), .rdata(rdata),
	.oscillator_trim_register(oscillator_trim_register), .sys_clk(sys_clk), .wdt_clk(wdt_clk),
	.core_reset_n(core_reset_n), .cpu_run(cpu_run), .divide_by_eight(divide_by_eight));

/* sim/css_clock_source_startup_select_tb.sv */
// self-checking bench for the clock source and start-up sequencer
`timescale 1ns/1ps

module css_clock_source_startup_select_tb;
	import css_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic slow = 1'b0;
	logic wake = 1'b0;
	logic [7:0] factory_cal = 8'h00;
	css_fuse_t fuse_in = 7'h14;
	css_bus_t bus = '0;
	css_osc_t osc;
	logic [7:0] rdata;
	logic [7:0] trim;
	logic sclk;
	logic core_n, cpu_run, div8;
	int err_count = 0;
	int n_compared = 0;
	css_fuse_t fz [11] = '{7'h14, 7'h11, 7'h13, 7'h17, 7'h21, 7'h01, 7'h31, 7'h35, 7'h41, 7'h29, 7'h11};
	int pr [11] = '{2, 2, 2, 2, 4, 8, 2, 2, 16, 2, 2};
	int rn [11] = '{14, 14, 14, 14, 14, 14, 1024, 39, 14, 14, 14};
	int wn [11] = '{16, 0, 512, 16, 0, 0, 512, 16, 0, 0, 0};
	int kn [11] = '{6, 6, 6, 6, 6, 6, 1024, 39, 6, 6, 6};

	css_clock_source_startup_select #(.WDT_64MS_CYCLES(16), .LFX_32K_CYCLES(40)) i_dut (
		.clk(clk), .nrst(nrst), .fuse_in(fuse_in), .factory_cal(factory_cal), .osc_in(osc),
		.wake(wake), .bus(bus), .rdata(rdata), .oscillator_trim_register(trim), .sys_clk(sclk),
		.wdt_clk(), .core_reset_n(core_n), .cpu_run(cpu_run), .divide_by_eight(div8));
	css_osc_model i_osc (.clk(clk), .nrst(nrst), .slow(slow), .osc(osc));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_in(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask
	// bounded wait, cycles counted from the current edge; sel picks cpu_run over core_n
	task automatic wait_hi(input bit sel, output int n);
		n = 0;
		while ((sel ? cpu_run : core_n) !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		int n, sl, lo, sc;
		logic sprev;
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			nrst <= 1'b0;
			fuse_in <= fz[i];
			slow <= (i == 10);
			factory_cal <= 8'hA5 ^ 8'(i);
			repeat (6) @(posedge clk);
			nrst <= 1'b1;
			sl = (i == 10) ? 2 : 1;
			lo = (rn[i] * pr[i] > wn[i] * 4) ? rn[i] * pr[i] : wn[i] * 4;
			lo = lo * sl;
			wait_hi(1'b0, n);
			// source phase at release may cost up to one source period
			chk_in("release", lo - pr[i] * sl - 2, lo + 8, n);
			chk("trim", 8'hA5 ^ 8'(i), trim);
			chk("div8", {7'h00, ~fz[i][0]}, {7'h00, div8});
			rd(8'h02, {1'b0, fz[i]}, "config");
			rd(8'h01, 8'h64, "status");
			// count system clock rises over 64 cycles
			sprev = sclk;
			sc = 0;
			for (int k = 0; k < 64; k++) begin
				@(posedge clk);
				#1;
				if (sclk === 1'b1 && sprev === 1'b0) begin
					sc++;
				end
				sprev = sclk;
			end
			chk("sys rate", 8'(64 / (pr[i] * sl)), 8'(sc));
			if (i == 0) begin
				wr(8'h00, 8'h3C);
				wr(8'h7F, 8'h55);
				wr(8'h02, 8'h00);
				rd(8'h00, 8'h3C, "trim rw");
				rd(8'h7F, 8'h00, "unmapped");
				rd(8'h02, {1'b0, fz[i]}, "config ro");
			end
			wr(8'h03, 8'h01);
			repeat (3) @(posedge clk);
			#1 chk("sleep", 8'h00, {7'h00, cpu_run});
			@(posedge clk);
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			lo = kn[i] * pr[i] * sl;
			wait_hi(1'b1, n);
			chk_in("wake", lo - pr[i] * sl - 2, lo + 8, n);
		end
		summarize();
	end
endmodule
